// ---- core/input_select_pkg.sv ----
// Constants, field layout and types for the sample A trio input-select block.
// =====================================================================
// Summary of operation
// - Bits 7 to 3 of the select register are unimplemented, read as zero and ignore writes.
// - Negative code 11 routes the trio to analog inputs 9/10/11 and code 10 to inputs 6/7/8.
// - A negative code with its upper bit clear routes the trio to the negative reference.
// - Positive bit set routes the trio to analog inputs 3/4/5, clear to inputs 0/1/2.
// - In 12-bit mode the negative field is unimplemented and reads as zero.
// - In 12-bit mode the positive bit is unimplemented and reads as zero.
// =====================================================================
`default_nettype none

package input_select_pkg;

    // =================================================================
    // Register map.
    localparam logic [11:0] select_offset    = 12'h000;
    localparam logic [11:0] mode_offset      = 12'h004;
    localparam logic [11:0] route_offset     = 12'h008;

    // =================================================================
    // Field positions and reset values.
    localparam int          pos_bit          = 0;
    localparam int          neg_lsb          = 1;
    localparam int          neg_msb          = 2;
    localparam logic [7:0]  select_implemented = 8'h07;
    localparam logic [7:0]  select_reset     = 8'h00;
    localparam logic        mode_reset       = 1'b0;
    localparam logic [11:0] pos_route_reset  = 12'h210;
    localparam logic [11:0] neg_route_ref    = 12'hfff;

    // =================================================================
    // Route status word: positive trio in 11:0, channel one negative, reference flag.
    localparam int          route_neg_lsb    = 16;
    localparam int          route_ref_bit    = 24;

    // =================================================================
    // Negative input choices; codes are the values of the negative select field.
    typedef enum logic [1:0] {
        neg_vref   = 2'b00,
        neg_in_678 = 2'b10,
        neg_in_9ab = 2'b11
    } neg_route_t;

    // Analog input numbers used by the routes.
    localparam logic [3:0]  pos_base_low     = 4'h0;
    localparam logic [3:0]  pos_base_high    = 4'h3;
    localparam logic [3:0]  neg_base_low     = 4'h6;
    localparam logic [3:0]  neg_base_high    = 4'h9;
    localparam logic [3:0]  neg_ref_code     = 4'hf;

endpackage : input_select_pkg

`default_nettype wire

// ---- core/select_fields_if.sv ----
// Interface carrying the stored select fields to the routing decoder.
`default_nettype none

interface select_fields_if;
    logic [1:0] neg_field;
    logic       pos_field;
    logic       twelve_bit;

    modport source (output neg_field, output pos_field, output twelve_bit);
    modport sink   (input neg_field, input pos_field, input twelve_bit);
endinterface : select_fields_if

`default_nettype wire

// ---- core/trio_route_decode.sv ----
// Decoder that turns the select fields into per-channel analog input numbers.
`default_nettype none

module trio_route_decode (
    input  wire logic        clk,
    input  wire logic        rst_n,
    select_fields_if.sink    fields,
    output logic [11:0]      pos_route,
    output logic [11:0]      neg_route,
    output logic             neg_is_ref
);

    logic [3:0]       next_pos_base;
    logic [3:0]       next_neg_base;
    logic             next_ref;
    wire logic [11:0] next_pos_route;
    wire logic [11:0] next_neg_route;

    // =================================================================
    // Base choice; 12-bit mode forces the low positive trio and the reference.
    always_comb begin
        next_pos_base = input_select_pkg::pos_base_low;
        next_neg_base = input_select_pkg::neg_ref_code;
        next_ref      = 1'b1;
        if (!fields.twelve_bit && fields.pos_field) begin
            next_pos_base = input_select_pkg::pos_base_high;
        end
        if (!fields.twelve_bit) begin
            case (fields.neg_field)
                2'b11: begin
                    next_neg_base = input_select_pkg::neg_base_high;
                    next_ref      = 1'b0;
                end
                2'b10: begin
                    next_neg_base = input_select_pkg::neg_base_low;
                    next_ref      = 1'b0;
                end
                default: begin
                    next_neg_base = input_select_pkg::neg_ref_code;
                    next_ref      = 1'b1;
                end
            endcase
        end
    end

    // =================================================================
    // One slice per trio channel; channel k takes the base input plus k, but on the reference every negative channel takes code f.
    for (genvar ch = 0; ch < 3; ch++) begin : g_channel
        assign next_pos_route[4*ch +: 4] = next_pos_base + 4'(ch);
        assign next_neg_route[4*ch +: 4] = next_ref ? input_select_pkg::neg_ref_code
                                                    : next_neg_base + 4'(ch);
    end

    // Registered routes: channel one in bits 3:0, two in 7:4, three in 11:8.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_route  <= input_select_pkg::pos_route_reset;
            neg_route  <= input_select_pkg::neg_route_ref;
            neg_is_ref <= 1'b1;
        end else begin
            pos_route  <= next_pos_route;
            neg_route  <= next_neg_route;
            neg_is_ref <= next_ref;
        end
    end

endmodule : trio_route_decode

`default_nettype wire

// ---- core/sample_a_select.sv ----
// AHB-Lite register slave for the sample A trio input select, with routing outputs.
`default_nettype none

module sample_a_select (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [11:0]      sample_a_pos_route,
    output logic [11:0]      sample_a_neg_route,
    output logic             sample_a_neg_is_ref
);

    logic [1:0]  sample_a_neg_input_select;
    logic        sample_a_pos_input_select;
    logic        twelve_bit_mode_select;
    logic        wr_pending;
    logic [11:0] wr_addr;
    logic        access;
    logic [7:0]  select_view;
    logic [31:0] route_view;

    select_fields_if fields ();

    assign access    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // =================================================================
    // Address phase capture; writes complete in the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr    <= 12'h000;
        end else begin
            wr_pending <= access && hwrite;
            wr_addr    <= haddr;
        end
    end

    // =================================================================
    // Stored fields; upper bits are not stored, so writes there vanish.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_a_neg_input_select <= input_select_pkg::select_reset[2:1];
            sample_a_pos_input_select <= input_select_pkg::select_reset[0];
        end else if (wr_pending && wr_addr == input_select_pkg::select_offset) begin
            sample_a_neg_input_select <= hwdata[input_select_pkg::neg_msb:
                                                input_select_pkg::neg_lsb];
            sample_a_pos_input_select <= hwdata[input_select_pkg::pos_bit];
        end
    end

    // Mode bit lives in its own register so software can steer the converter width.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            twelve_bit_mode_select <= input_select_pkg::mode_reset;
        end else if (wr_pending && wr_addr == input_select_pkg::mode_offset) begin
            twelve_bit_mode_select <= hwdata[0];
        end
    end

    // =================================================================
    // Read view; 12-bit mode hides both fields, stored values survive the mode.
    always_comb begin
        select_view = 8'h00;
        if (!twelve_bit_mode_select) begin
            select_view[2:1] = sample_a_neg_input_select;
            select_view[0]   = sample_a_pos_input_select;
        end
    end

    // Route status view; only channel one of the negative trio is shown, in bits 19:16 below the flag,
    // which is enough to tell the three negative choices apart.
    always_comb begin
        route_view = 32'h0000_0000;
        route_view[11:0] = sample_a_pos_route;
        route_view[input_select_pkg::route_neg_lsb +: 4] = sample_a_neg_route[3:0];
        route_view[input_select_pkg::route_ref_bit] = sample_a_neg_is_ref;
    end

    // Read data registered at the address phase, valid in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (access && !hwrite) begin
            case (haddr)
                input_select_pkg::select_offset: hrdata <= {24'h00_0000, select_view};
                input_select_pkg::mode_offset:   hrdata <= {31'h0000_0000,
                                                            twelve_bit_mode_select};
                input_select_pkg::route_offset:  hrdata <= route_view;
                default:                         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // Routing applies to the sample A trio only.
    assign fields.neg_field  = sample_a_neg_input_select;
    assign fields.pos_field  = sample_a_pos_input_select;
    assign fields.twelve_bit = twelve_bit_mode_select;

    trio_route_decode trio_route_decode_inst (
        .clk        (hclk),
        .rst_n      (hresetn),
        .fields     (fields),
        .pos_route  (sample_a_pos_route),
        .neg_route  (sample_a_neg_route),
        .neg_is_ref (sample_a_neg_is_ref)
    );

    // =================================================================
    // Read path: what software sees of the select and status registers.
    // Read data are registered at the address phase, so each check looks one edge later.
    a_hidden_read: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::select_offset && twelve_bit_mode_select
        |=> hrdata[2:0] == 3'b000)
        else $error("select fields visible in 12-bit mode");

    a_hidden_pos: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::select_offset && twelve_bit_mode_select
        |=> !hrdata[0])
        else $error("positive select bit visible in 12-bit mode");

    a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::select_offset
        |=> hrdata[31:3] == 29'h0000_0000)
        else $error("unimplemented select bits read nonzero");

    a_neg_visible: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::select_offset && !twelve_bit_mode_select
        |=> hrdata[2:1] == $past(sample_a_neg_input_select))
        else $error("negative select field read back wrong");

    a_pos_visible: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::select_offset && !twelve_bit_mode_select
        |=> hrdata[0] == $past(sample_a_pos_input_select))
        else $error("positive select bit read back wrong");

    a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr != input_select_pkg::select_offset
        && haddr != input_select_pkg::mode_offset && haddr != input_select_pkg::route_offset
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped address read nonzero");

    a_route_read: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::route_offset
        |=> hrdata[input_select_pkg::route_ref_bit] == $past(sample_a_neg_is_ref))
        else $error("route status reference flag read back wrong");

    a_route_pos_read: assert property (@(posedge hclk) disable iff (!hresetn)
        access && !hwrite && haddr == input_select_pkg::route_offset
        |=> hrdata[11:0] == $past(sample_a_pos_route))
        else $error("route status positive trio read back wrong");

    // =================================================================
    // Write path: a data-phase write lands at its edge and nothing else moves the fields.
    // A field that drifts without a write would re-steer the converter behind software.
    a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pending && wr_addr == input_select_pkg::select_offset
        |=> sample_a_pos_input_select == $past(hwdata[0]))
        else $error("select write did not land");

    a_neg_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pending && wr_addr == input_select_pkg::select_offset
        |=> sample_a_neg_input_select == $past(hwdata[2:1]))
        else $error("negative select write did not land");

    a_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pending && wr_addr == input_select_pkg::mode_offset
        |=> twelve_bit_mode_select == $past(hwdata[0]))
        else $error("mode write did not land");

    a_field_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_pending && wr_addr == input_select_pkg::select_offset)
        |=> $stable(sample_a_neg_input_select) && $stable(sample_a_pos_input_select))
        else $error("select fields changed without a write");

    // =================================================================
    // Routing: the decoder outputs follow the stored fields one edge later.
    // In 12-bit mode the hidden fields must not steer anything either.
    a_pos_high: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_a_pos_input_select && !twelve_bit_mode_select |=> sample_a_pos_route == 12'h543)
        else $error("positive trio not routed to inputs 3 to 5");

    a_pos_low: assert property (@(posedge hclk) disable iff (!hresetn)
        !sample_a_pos_input_select || twelve_bit_mode_select |=> sample_a_pos_route == 12'h210)
        else $error("positive trio not routed to inputs 0 to 2");

    a_neg_high: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_a_neg_input_select == 2'b11 && !twelve_bit_mode_select
        |=> sample_a_neg_route == 12'hba9 && !sample_a_neg_is_ref)
        else $error("negative trio not routed to inputs 9 to 11");

    a_neg_mid: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_a_neg_input_select == 2'b10 && !twelve_bit_mode_select
        |=> sample_a_neg_route == 12'h876)
        else $error("negative trio not routed to inputs 6 to 8");

    a_neg_mid_live: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_a_neg_input_select == 2'b10 && !twelve_bit_mode_select
        |=> !sample_a_neg_is_ref)
        else $error("negative trio left on reference for code 10");

    a_neg_ref: assert property (@(posedge hclk) disable iff (!hresetn)
        !sample_a_neg_input_select[1] |=> sample_a_neg_is_ref)
        else $error("negative trio not on reference");

    a_neg_ref_route: assert property (@(posedge hclk) disable iff (!hresetn)
        !sample_a_neg_input_select[1] |=> sample_a_neg_route == 12'hfff)
        else $error("negative route not parked while on reference");

    a_mode_neg_ref: assert property (@(posedge hclk) disable iff (!hresetn)
        twelve_bit_mode_select |=> sample_a_neg_is_ref)
        else $error("negative trio steered by a hidden field in 12-bit mode");

endmodule : sample_a_select

`default_nettype wire

// ---- verification/analog_trio_model.sv ----
// Behavioural model of the analog multiplexer and sample-and-hold trio.
`default_nettype none

module analog_trio_model (
    input  wire logic [11:0] pos_route,
    input  wire logic [11:0] neg_route,
    input  wire logic        neg_is_ref,
    output logic      [11:0] pos_level,
    output logic      [11:0] neg_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each analog input n carries level n xor 5, so a wrong route shows a wrong level.
    // The reference carries zero, which no input routed to the negative trio can produce by accident.
    always_comb begin
        pos_level = pos_route ^ 12'h0555;
        neg_level = neg_is_ref ? 12'h0000 : (neg_route ^ 12'h0555);
    end
endmodule : analog_trio_model

`default_nettype wire

// ---- verification/sample_a_select_bench.sv ----
// Self-checking bench for the sample A trio input-select register block.
`default_nettype none

module sample_a_select_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [11:0] pos_route;
    logic [11:0] neg_route;
    logic        neg_is_ref;
    logic [11:0] pos_level;
    logic [11:0] neg_level;
    logic [31:0] rd;
    int          err_count;
    int          checks_done;

    // =====================================================================
    // Instances
    sample_a_select sample_a_select_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sample_a_pos_route(pos_route), .sample_a_neg_route(neg_route),
        .sample_a_neg_is_ref(neg_is_ref));
    analog_trio_model analog_trio_model_inst (.pos_route(pos_route), .neg_route(neg_route),
        .neg_is_ref(neg_is_ref), .pos_level(pos_level), .neg_level(neg_level));

    // Free-running 125 MHz bus clock.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // =====================================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Bounded wait for hready, so a stuck slave cannot hang the run.
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 100) check("hready wait", 32'h0000_0000, 32'h0000_0001);
    endtask : wait_ready

    // One AHB-Lite single word transfer; read data are taken at the data-phase edge.
    task automatic bus(input logic [11:0] addr, input logic wr, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr  <= addr;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("response", {31'h0, hresp}, 32'h0000_0000);
    endtask : bus

    // Every select code, with the unimplemented upper bits written as ones.
    task automatic all_codes;
        logic [11:0] ep;
        logic [11:0] en;
        for (int v = 0; v < 8; v++) begin
            bus(input_select_pkg::select_offset, 1'b1, 32'hffff_fff8 | v);
            bus(input_select_pkg::select_offset, 1'b0, 32'h0000_0000);
            check("select read", rd, v);
            ep = v[0] ? 12'h543 : 12'h210;
            en = (v[2:1] == 2'b11) ? 12'hba9 : (v[2:1] == 2'b10) ? 12'h876 : 12'hfff;
            check("pos route", {20'h0, pos_route}, {20'h0, ep});
            check("neg route", {20'h0, neg_route}, {20'h0, en});
            check("neg on ref", {31'h0, neg_is_ref}, {31'h0, !v[2]});
            check("pos level", {20'h0, pos_level}, {20'h0, ep ^ 12'h555});
            check("neg level", {20'h0, neg_level}, {20'h0, (v[2] ? (en ^ 12'h555) : 12'h000)});
            bus(input_select_pkg::route_offset, 1'b0, 32'h0000_0000);
            check("route status", rd, {7'h00, !v[2], 4'h0, en[3:0], 4'h0, ep});
        end
    endtask : all_codes

    // In 12-bit mode both fields read as zero; the stored code returns afterwards.
    task automatic twelve_bit_mode;
        bus(input_select_pkg::select_offset, 1'b1, 32'h0000_0007);
        bus(input_select_pkg::mode_offset, 1'b1, 32'h0000_0001);
        bus(input_select_pkg::select_offset, 1'b0, 32'h0000_0000);
        check("neg field in mode", {30'h0, rd[2:1]}, 32'h0000_0000);
        check("pos field in mode", {31'h0, rd[0]}, 32'h0000_0000);
        check("pos route in mode", {20'h0, pos_route}, 32'h0000_0210);
        check("neg ref in mode", {31'h0, neg_is_ref}, 32'h0000_0001);
        bus(input_select_pkg::mode_offset, 1'b0, 32'h0000_0000);
        check("mode read", rd, 32'h0000_0001);
        bus(input_select_pkg::route_offset, 1'b0, 32'h0000_0000);
        check("route status in mode", rd, 32'h010f_0210);
        bus(input_select_pkg::mode_offset, 1'b1, 32'h0000_0000);
        bus(input_select_pkg::select_offset, 1'b0, 32'h0000_0000);
        check("select after mode", rd, 32'h0000_0007);
        bus(12'h00c, 1'b0, 32'h0000_0000);
        check("unmapped read", rd, 32'h0000_0000);
    endtask : twelve_bit_mode

    task automatic finish_test;
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // =====================================================================
    // Main sequence: reset, then the scenarios back to back.
    initial begin
        err_count = 0;
        checks_done = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("reset neg ref", {31'h0, neg_is_ref}, 32'h0000_0001);
        check("reset pos route", {20'h0, pos_route}, 32'h0000_0210);
        bus(input_select_pkg::select_offset, 1'b0, 32'h0000_0000);
        check("reset select", rd, 32'h0000_0000);
        all_codes();
        twelve_bit_mode();
        finish_test();
    end

    // Watchdog: the scenarios need well under a thousand cycles.
    initial begin
        #80000;
        err_count++;
        finish_test();
    end
endmodule : sample_a_select_bench

`default_nettype wire
